// *** pixcap_pkg.sv ***
// Shared constants for the dual pixel input capture block
package pixcap_pkg;
  localparam int unsigned PIX_W       = 24;            // Bits per pixel
  localparam int unsigned CTL_W       = 5;             // Hsync, vsync, three aux controls
  localparam int unsigned WORD_W      = 2 * PIX_W + 1 + CTL_W + 1; // Odd, even, qual, ctl, dual
  localparam int unsigned FIFO_DEPTH  = 16;            // Words buffered toward the encoder
  localparam int unsigned FIFO_AW     = 4;             // Address bits for FIFO_DEPTH
  localparam int unsigned SYNC_STAGES = 2;             // Flops on every pin input
  localparam logic [1:0]  SYNC_RST    = 2'h0;          // Synchroniser value after reset
  localparam logic        CLK_RST     = 1'h0;          // Pixel clock history after reset
  // Bit positions of the forwarded word
  localparam int unsigned POS_EVEN    = 0;
  localparam int unsigned POS_ODD     = PIX_W;
  localparam int unsigned POS_QUAL    = 2 * PIX_W;
  localparam int unsigned POS_CTL     = 2 * PIX_W + 1;
  localparam int unsigned POS_DUAL    = 2 * PIX_W + 1 + CTL_W;
endpackage

// *** pixcap_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pixcap_fifo #(
  parameter int unsigned WIDTH = 55,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk,        // System clock
  input  wire logic             resetn,     // Async reset, active low
  input  wire logic             ce,         // Clock enable
  input  wire logic             flush,      // Empty the FIFO
  input  wire logic [WIDTH-1:0] in_data,    // Write data
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Space available
  output logic [WIDTH-1:0]      out_data,   // Read data, registered
  output logic                  out_valid,  // Read data present
  input  wire logic             out_ready   // Consumer takes a word
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign empty    = (wr_q == rd_q);
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign pop      = !empty && (!out_valid || out_ready);
  assign push     = in_valid && in_ready;

  // Storage array, no reset needed
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wr_q <= '0;
        rd_q <= '0;
      end
      else
      begin
        if (push)
          wr_q <= wr_q + 1'b1;
        if (pop)
          rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Output register stage keeps read data off the array
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (ce)
    begin
      if (flush)
        out_valid <= 1'b0;
      else if (pop)
      begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_q[AW-1:0]];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

// *** pixcap_sync.sv ***
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module pixcap_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,     // System clock
  input  wire logic             resetn,  // Async reset, active low
  input  wire logic             ce,      // Clock enable
  input  wire logic [WIDTH-1:0] async_i, // Pin level
  output logic [WIDTH-1:0]      sync_o   // Synchronised level
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (ce)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// *** dual_pixel_input_capture.sv ***
// Dual pixel input capture: samples the pixel port and forwards aligned words
`timescale 1ns/1ps
module dual_pixel_input_capture (
  input  wire logic                     clk_sys,                 // 20 MHz system clock
  input  wire logic                     resetn,                  // Async reset, active low
  input  wire logic                     clk_en,                  // Freezes all state when low
  input  wire logic                     input_pixel_clock,       // Pixel clock pin
  input  wire logic [pixcap_pkg::PIX_W-1:0] even_pixel_bus,     // First or only pixel
  input  wire logic [pixcap_pkg::PIX_W-1:0] odd_pixel_bus,      // Second pixel
  input  wire logic                     active_video_qualifier,  // High in active region
  input  wire logic                     hsync_in,                // Horizontal sync
  input  wire logic                     vsync_in,                // Vertical sync
  input  wire logic                     aux_control_1,           // General control 1
  input  wire logic                     aux_control_2,           // General control 2
  input  wire logic                     aux_control_3,           // General control 3
  input  wire logic                     latch_edge_strap,        // 1 rising, 0 falling
  input  wire logic                     pixels_per_clock_strap,  // 1 dual, 0 single
  input  wire logic                     power_down_n,            // Power down, active low
  output logic [pixcap_pkg::PIX_W-1:0]  enc_even_pixel,          // First pixel to encoder
  output logic [pixcap_pkg::PIX_W-1:0]  enc_odd_pixel,           // Second pixel, zero if single
  output logic                          enc_active,              // Word is pixel data
  output logic [pixcap_pkg::CTL_W-1:0]  enc_controls,            // {aux_control_3,aux_control_2,aux_control_1,vs,hs}
  output logic                          enc_dual,                // Word carries two pixels
  output logic                          enc_valid,               // Word present
  input  wire logic                     enc_ready,               // Encoder takes word
  output logic                          enc_drive_en,            // Outputs driven, low = tristate
  output logic                          capture_overflow         // Sticky: word lost, FIFO full
);
  localparam int unsigned NIN = 2 * pixcap_pkg::PIX_W + 1 + pixcap_pkg::CTL_W + 3;
  localparam int unsigned W   = pixcap_pkg::WORD_W;

  logic [NIN-1:0] pins_raw;
  logic [NIN-1:0] pins_s;
  logic [pixcap_pkg::PIX_W-1:0] even_s;
  logic [pixcap_pkg::PIX_W-1:0] odd_s;
  logic                         qual_s;
  logic [pixcap_pkg::CTL_W-1:0] ctl_s;
  logic                         clk_s;
  logic                         edge_s;
  logic                         dual_s;
  logic                         pd_n_s;
  logic                         clk_prev_q;
  logic                         rise;
  logic                         fall;
  logic                         sample;
  logic [W-1:0]                 cap_d;
  logic [W-1:0]                 cap_q;
  logic                         cap_valid_q;
  logic                         fifo_in_ready;
  logic [W-1:0]                 fifo_data;
  logic                         fifo_valid;
  logic                         fifo_pop;
  logic                         flush;
  logic                         ovf_q;

  // Every pin except the pixel clock crosses in through one synchroniser bank
  assign pins_raw = {power_down_n, pixels_per_clock_strap, latch_edge_strap,
                     aux_control_3, aux_control_2, aux_control_1, vsync_in, hsync_in,
                     active_video_qualifier, odd_pixel_bus, even_pixel_bus};

  pixcap_sync #(
    .WIDTH (NIN)
  ) u_sync (
    .clk     (clk_sys),
    .resetn  (resetn),
    .ce      (clk_en),
    .async_i (pins_raw),
    .sync_o  (pins_s)
  );

  // The pixel clock is a level too; its own two flops keep it separate
  pixcap_sync #(
    .WIDTH (1)
  ) u_clk_sync (
    .clk     (clk_sys),
    .resetn  (resetn),
    .ce      (clk_en),
    .async_i (input_pixel_clock),
    .sync_o  (clk_s)
  );

  assign even_s = pins_s[pixcap_pkg::PIX_W-1:0];
  assign odd_s  = pins_s[2*pixcap_pkg::PIX_W-1:pixcap_pkg::PIX_W];
  assign qual_s = pins_s[2*pixcap_pkg::PIX_W];
  assign ctl_s  = pins_s[2*pixcap_pkg::PIX_W+pixcap_pkg::CTL_W:2*pixcap_pkg::PIX_W+1];
  assign edge_s = pins_s[NIN-3];
  assign dual_s = pins_s[NIN-2];
  assign pd_n_s = pins_s[NIN-1];

  // Edge detector on the synchronised pixel clock
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      clk_prev_q <= pixcap_pkg::CLK_RST;
    else if (clk_en)
      clk_prev_q <= clk_s;
  end

  assign rise = clk_s && !clk_prev_q;
  assign fall = !clk_s && clk_prev_q;

  // edge select
  // Data and clock share equal sync delay, so the edge sees data aligned to it
  assign sample = pd_n_s && (edge_s ? rise : fall);

  // pixel packing
  // Odd bus is forced to zero in single mode so stray levels never reach the encoder
  // qualifier and controls travel with the pixels
  always_comb
  begin
    cap_d = '0;
    cap_d[pixcap_pkg::POS_EVEN +: pixcap_pkg::PIX_W] = even_s;
    cap_d[pixcap_pkg::POS_ODD +: pixcap_pkg::PIX_W]  = dual_s ? odd_s : '0;
    cap_d[pixcap_pkg::POS_QUAL]                      = qual_s;
    cap_d[pixcap_pkg::POS_CTL +: pixcap_pkg::CTL_W]  = ctl_s;
    cap_d[pixcap_pkg::POS_DUAL]                      = dual_s;
  end

  // power down
  // Flush drops buffered words; nothing stale leaks out after wake-up
  assign flush = !pd_n_s;

  // capture register, one word per sampled edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_q       <= '0;
      cap_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cap_valid_q <= sample;
      if (sample)
        cap_q <= cap_d;
    end
  end

  // Overflow is sticky until power down; the input side cannot be stalled
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ovf_q <= 1'b0;
    else if (clk_en)
    begin
      if (cap_valid_q && !fifo_in_ready)
        ovf_q <= 1'b1;
      else if (flush)
        ovf_q <= 1'b0;
    end
  end

  pixcap_fifo #(
    .WIDTH (W),
    .DEPTH (pixcap_pkg::FIFO_DEPTH),
    .AW    (pixcap_pkg::FIFO_AW)
  ) u_fifo (
    .clk       (clk_sys),
    .resetn    (resetn),
    .ce        (clk_en),
    .flush     (flush),
    .in_data   (cap_q),
    .in_valid  (cap_valid_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Output stage: skid-free register, loads when empty or taken
  assign fifo_pop = !enc_valid || enc_ready;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      enc_even_pixel <= '0;
      enc_odd_pixel  <= '0;
      enc_active     <= 1'b0;
      enc_controls   <= '0;
      enc_dual       <= 1'b0;
      enc_valid      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (flush)
        enc_valid <= 1'b0;
      else if (fifo_pop)
      begin
        enc_valid      <= fifo_valid;
        if (fifo_valid)
        begin
          enc_even_pixel <= fifo_data[pixcap_pkg::POS_EVEN +: pixcap_pkg::PIX_W];
          enc_odd_pixel  <= fifo_data[pixcap_pkg::POS_ODD +: pixcap_pkg::PIX_W];
          enc_active     <= fifo_data[pixcap_pkg::POS_QUAL];
          enc_controls   <= fifo_data[pixcap_pkg::POS_CTL +: pixcap_pkg::CTL_W];
          enc_dual       <= fifo_data[pixcap_pkg::POS_DUAL];
        end
      end
    end
  end

  // output drive enable and flags from flops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      enc_drive_en     <= 1'b0;
      capture_overflow <= 1'b0;
    end
    else if (clk_en)
    begin
      enc_drive_en     <= pd_n_s;
      capture_overflow <= ovf_q;
    end
  end
endmodule

// *** pixcap_asserts.sv ***
// Concurrent checks on the pixel capture ports
`timescale 1ns/1ps
module pixcap_asserts (
  input wire logic                          clk_sys,                // Clock
  input wire logic                          resetn,                 // Reset
  input wire logic                          input_pixel_clock,      // Pin
  input wire logic                          latch_edge_strap,       // Strap
  input wire logic                          pixels_per_clock_strap, // Strap
  input wire logic                          power_down_n,           // Pin
  input wire logic [pixcap_pkg::PIX_W-1:0]  enc_even_pixel,         // Out
  input wire logic [pixcap_pkg::PIX_W-1:0]  enc_odd_pixel,          // Out
  input wire logic [pixcap_pkg::CTL_W-1:0]  enc_controls,           // Out
  input wire logic                          enc_active,             // Out
  input wire logic                          enc_dual,               // Out
  input wire logic                          enc_valid,              // Out
  input wire logic                          enc_ready,              // In
  input wire logic                          enc_drive_en,           // Out
  input wire logic                          capture_overflow        // Out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Pin levels held long enough to pass the input flops
  sequence pd_low; !power_down_n [*4]; endsequence
  sequence pd_high; power_down_n [*5]; endsequence
  // A word caught just before power down may set overflow once more before flush clears it
  sequence pd_long; !power_down_n [*6]; endsequence
  sequence rise_seen; $rose(input_pixel_clock) && latch_edge_strap; endsequence
  sequence fall_seen; $fell(input_pixel_clock) && !latch_edge_strap; endsequence
  drive_off_a: assert property (pd_low |-> !enc_drive_en && !enc_valid)
    else $error("output driven in power down");
  no_ovf_pd_a: assert property (pd_long |-> !capture_overflow)
    else $error("overflow kept in power down");
  drive_on_a: assert property (pd_high |-> enc_drive_en)
    else $error("outputs not driven while powered");
  hold_word_a: assert property (pd_high ##0 (enc_valid && !enc_ready) |=> enc_valid
    && $stable(enc_even_pixel) && $stable(enc_odd_pixel) && $stable(enc_controls)
    && $stable(enc_active)) else $error("word changed before taken");
  odd_zero_a: assert property (enc_valid && !enc_dual |-> enc_odd_pixel == 24'h0)
    else $error("odd pixel in single mode");
  dual_strap_a: assert property ($stable(pixels_per_clock_strap) [*8] ##0 enc_valid
    |-> enc_dual == pixels_per_clock_strap) else $error("dual flag wrong");
  rise_word_a: assert property (pd_high ##0 rise_seen |-> ##[2:8] enc_valid)
    else $error("no word after rising edge");
  fall_word_a: assert property (pd_high ##0 fall_seen |-> ##[2:8] enc_valid)
    else $error("no word after falling edge");
  ovf_sticky_a: assert property (pd_high ##0 capture_overflow |=> capture_overflow)
    else $error("overflow flag dropped");
endmodule
bind dual_pixel_input_capture pixcap_asserts u_chk (.*);

// *** pixel_source.sv ***
// Graphics controller model driving the parallel pixel port
`timescale 1ns/1ps
module pixel_source (
  input  wire logic                    clk_sys,  // Bench clock
  output logic                         pclk,     // Pixel clock, still between words
  output logic [pixcap_pkg::PIX_W-1:0] even_bus, // First pixel
  output logic [pixcap_pkg::PIX_W-1:0] odd_bus,  // Second pixel
  output logic                         qual,     // Active video qualifier
  output logic [pixcap_pkg::CTL_W-1:0] ctl       // {aux_control_3,aux_control_2,aux_control_1,vs,hs}
);
  initial
  begin
    pclk = 1'b0;
    even_bus = 24'h0;
    odd_bus = 24'h0;
    qual = 1'b0;
    ctl = 5'h0;
  end
  // one 400 ns period per word; the inactive edge sees inverted buses
  task automatic send(input logic rise_m, input logic [23:0] e, input logic [23:0] o,
                      input logic q, input logic [4:0] c);
    begin
      even_bus = rise_m ? e : ~e;
      odd_bus = rise_m ? o : ~o;
      qual = q;
      ctl = c;
      repeat (2) @(negedge clk_sys);
      pclk = 1'b1;
      repeat (2) @(negedge clk_sys);
      even_bus = rise_m ? ~e : e;
      odd_bus = rise_m ? ~o : o;
      repeat (2) @(negedge clk_sys);
      pclk = 1'b0;
      repeat (2) @(negedge clk_sys);
      // Released buses show the last word in rising mode and its inverse in falling mode
      even_bus = ~even_bus;
      odd_bus = ~odd_bus;
    end
  endtask
endmodule

// *** dual_pixel_input_capture_tb.sv ***
// Self-checking bench for the dual pixel input capture block
`timescale 1ns/1ps
module dual_pixel_input_capture_tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        edge_s = 1'b0;
  logic        pix_s = 1'b0;
  logic        power_down_n = 1'b1;
  logic        enc_ready = 1'b1;
  logic [1:0]  rmode = 2'h2;     // 0 random, 1 stalled, 2 always ready
  logic        last_q = 1'b0;
  logic [4:0]  last_c = 5'h0;
  int          seed = 32'hA81F41FE;
  int          err_total = 0;
  int          n_checks = 0;
  int          m, k, i;
  logic [pixcap_pkg::WORD_W-1:0] exp_q[$];
  wire logic [pixcap_pkg::PIX_W-1:0] even_bus, odd_bus, enc_even_pixel, enc_odd_pixel;
  wire logic [pixcap_pkg::CTL_W-1:0] ctl, enc_controls;
  wire logic   pclk, qual, enc_active, enc_dual, enc_valid, enc_drive_en, capture_overflow;

  pixel_source src (.clk_sys(clk_sys), .pclk(pclk), .even_bus(even_bus), .odd_bus(odd_bus),
                    .qual(qual), .ctl(ctl));
  dual_pixel_input_capture dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
    .input_pixel_clock(pclk), .even_pixel_bus(even_bus), .odd_pixel_bus(odd_bus),
    .active_video_qualifier(qual), .hsync_in(ctl[0]), .vsync_in(ctl[1]),
    .aux_control_1(ctl[2]), .aux_control_2(ctl[3]), .aux_control_3(ctl[4]),
    .latch_edge_strap(edge_s), .pixels_per_clock_strap(pix_s), .power_down_n(power_down_n),
    .enc_even_pixel(enc_even_pixel), .enc_odd_pixel(enc_odd_pixel), .enc_active(enc_active),
    .enc_controls(enc_controls), .enc_dual(enc_dual), .enc_valid(enc_valid),
    .enc_ready(enc_ready), .enc_drive_en(enc_drive_en), .capture_overflow(capture_overflow));

  always #25 clk_sys = ~clk_sys;
  // Consumer stalls at random in rmode 0 and always in rmode 1, so words pile up in the FIFO
  always @(negedge clk_sys)
    enc_ready <= (rmode == 2'h0) ? 1'($random(seed)) : rmode[1];

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        err_total++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task automatic final_report;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Expected word: odd bus zeroed in single mode, dual flag from pix_s
  function automatic logic [pixcap_pkg::WORD_W-1:0] exp_word(input logic [23:0] e,
      input logic [23:0] o, input logic q, input logic [4:0] c);
    return {pix_s, c, q, pix_s ? o : 24'h0, e};
  endfunction

  task automatic send_word(input logic [23:0] e, input logic [23:0] o, input logic q);
    logic [4:0] c;
    begin
      c = 5'($random(seed));
      // controls held across a qualifier change
      if (q !== last_q) c = last_c;
      last_q = q;
      last_c = c;
      if (power_down_n) exp_q.push_back(exp_word(e, o, q, c));
      src.send(edge_s, e, o, q, c);
    end
  endtask

  task automatic drain;
    begin
      rmode = 2'h2;
      for (i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clk_sys);
      check("words left", exp_q.size(), 0);
    end
  endtask

  // Every taken word is compared in order against the queue
  always @(posedge clk_sys)
    if (resetn && enc_valid === 1'b1 && enc_ready === 1'b1)
    begin
      if (exp_q.size() == 0) check("extra word", 1, 0);
      else check("word", {enc_dual, enc_controls, enc_active, enc_odd_pixel,
                          enc_even_pixel}, exp_q.pop_front());
    end

  initial
  begin
    #2000000;
    err_total++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    // Every strap combination, corner words then random traffic
    for (m = 0; m < 4; m++)
    begin
      edge_s = m[0];
      pix_s = m[1];
      repeat (8) @(negedge clk_sys);
      rmode = 2'h0;
      send_word(24'hFFFFFF, 24'h000000, 1'b1);
      send_word(24'h000000, 24'hFFFFFF, 1'b0);
      for (k = 0; k < 10; k++) send_word(24'($random(seed)), 24'($random(seed)), 1'($random(seed)));
      drain();
    end
    // Stalled consumer until words are lost, then power down with the FIFO full
    rmode = 2'h1;
    for (k = 0; k < 22; k++) send_word(24'($random(seed)), 24'($random(seed)), 1'b1);
    check("overflow", capture_overflow, 1);
    power_down_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    exp_q.delete();
    rmode = 2'h2;
    check("drive off", enc_drive_en, 0);
    check("valid off", enc_valid, 0);
    check("overflow cleared", capture_overflow, 0);
    send_word(24'h123456, 24'h654321, 1'b1);
    repeat (10) @(negedge clk_sys);
    power_down_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("drive on", enc_drive_en, 1);
    rmode = 2'h0;
    for (k = 0; k < 6; k++) send_word(24'($random(seed)), 24'($random(seed)), 1'($random(seed)));
    drain();
    final_report();
  end
endmodule
